/* File: src/dcf_pkg.sv */
package dcf_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int DATA_W      = 8;
    localparam int FIFO_DEPTH  = 1024;
    localparam int PRIM_DEPTH  = 512;      // One primitive with error correction
    localparam int PTR_W       = 10;
    localparam int CNT_W       = 11;
    localparam int EV_W        = 4;        // Event count width per pipe stage
    localparam int BUF_DEPTH   = 2;

    // ------------------------------------------------------------------
    // Cascade depth factor
    // ------------------------------------------------------------------
    localparam bit NEWER_FAMILY      = 1'b0;
    localparam int SMALL_CASCADE_MAX = 12;
    localparam int CASCADE_N         = FIFO_DEPTH / PRIM_DEPTH;
    localparam int N_EFF             = (NEWER_FAMILY && CASCADE_N <= SMALL_CASCADE_MAX)
                                       ? 1 : CASCADE_N;

    // ------------------------------------------------------------------
    // Clock rates and dividers
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int WR_CLK_PERIOD_NS = 20;
    localparam int RD_CLK_PERIOD_NS = 30;
    localparam int DIV_W            = 8;
    localparam int WR_DIV           = WR_CLK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int RD_DIV           = RD_CLK_PERIOD_NS / CLK_PERIOD_NS;
    localparam bit FAST_IS_WR       = (WR_DIV <= RD_DIV);

    // ------------------------------------------------------------------
    // Latency figures: origin ticks, quicker-clock ticks per step, far ticks
    // ------------------------------------------------------------------
    localparam int FULL_L1  = 1;
    localparam int FULL_L2  = 4;
    localparam int FULL_L3  = 3;
    localparam int PFULL_L4 = 1;
    localparam int PFULL_L5 = 4;
    localparam int EMPS_L1  = 1;
    localparam int EMPS_L2  = 4;
    localparam int EMPS_L3  = 4;
    localparam int EMPP_L2  = 5;
    localparam int PEMP_L4  = 1;
    localparam int PEMP_L5  = 5;
    localparam int PEMP_L6  = 4;

    // Pipe segments; the last far tick of a programmable flag is its own register
    localparam int FULL_SEG_B  = (N_EFF - 1) * FULL_L2;
    localparam int PFULL_SEG_B = (N_EFF - 1) * (FULL_L2 - 1);
    localparam int PFULL_SEG_C = PFULL_L5 - 1;
    localparam int EMPS_SEG_B  = (N_EFF - 1) * EMPS_L2;
    localparam int EMPP_SEG_B  = (N_EFF - 1) * EMPP_L2;
    localparam int PEMP_SEG_B  = (N_EFF - 1) * (PEMP_L5 - 1);
    localparam int PEMP_SEG_C  = PEMP_L6 - 1;

    // ------------------------------------------------------------------
    // Thresholds and reset values
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] PROG_FULL_THR  = 11'h3_E8;
    localparam logic [CNT_W-1:0] PROG_EMPTY_THR = 11'h0_08;
    localparam logic [CNT_W-1:0] FULL_LEVEL     = 11'h4_00;
    localparam logic [CNT_W-1:0] CNT_RST        = 11'h0_00;
    localparam logic [PTR_W-1:0] PTR_RST        = 10'h0_00;
    localparam logic [DIV_W-1:0] DIV_RST        = 8'h0_0;
    localparam logic             EMPTY_RST      = 1'b1;
    localparam logic             FULL_RST       = 1'b0;

endpackage : dcf_pkg

/* File: src/dcf_lat_pipe.sv */
`timescale 1ns/1ps
module dcf_lat_pipe #(
    parameter int SEG_A = 1,
    parameter int SEG_B = 0,
    parameter int SEG_C = 1
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    tick_a_i,
    input  wire logic                    tick_b_i,
    input  wire logic                    tick_c_i,
    input  wire logic [dcf_pkg::EV_W-1:0] ev_i,
    output logic      [dcf_pkg::EV_W-1:0] ev_o
);
    import dcf_pkg::*;

    localparam int LEN = SEG_A + SEG_B + SEG_C;

    logic [EV_W-1:0] stage_q [LEN];
    logic [EV_W-1:0] stage_d [LEN];
    logic            stage_tick [LEN];

    // ------------------------------------------------------------------
    // Stages hold event counts so bursts on a fast side are not merged away
    // ------------------------------------------------------------------
    for (genvar i = 0; i < LEN; i++)
    begin : g_stage
        assign stage_tick[i] = (i < SEG_A) ? tick_a_i :
                               ((i < SEG_A + SEG_B) ? tick_b_i : tick_c_i);
        if (i == 0)
        begin : g_first
            always_comb
            begin
                stage_d[i] = (stage_tick[i] ? '0 : stage_q[i]) + ev_i;
            end
        end
        else
        begin : g_next
            always_comb
            begin
                stage_d[i] = (stage_tick[i] ? '0 : stage_q[i])
                           + (stage_tick[i-1] ? stage_q[i-1] : '0);
            end
        end
        always_ff @(posedge clk_i)
        begin
            if (!rst_n_i)
                stage_q[i] <= '0;
            else
                stage_q[i] <= stage_d[i];
        end
    end

    assign ev_o = stage_tick[LEN-1] ? stage_q[LEN-1] : '0;

endmodule : dcf_lat_pipe

/* File: src/dcf_fifo_flags.sv */
`timescale 1ns/1ps
// Function
// - Cascade depth factor is configured depth over primitive depth, 512 with ECC.
// - Cross-primitive terms count ticks of the quicker of read and write clocks.
// - Newer family with at most 12 primitives uses a factor of one.
// - Write updates full at once, programmable full one write tick later.
// - Write acknowledge and overflow answer a write attempt without added latency.
// - Read updates empty at once, programmable empty one read tick later.
// - Valid and underflow answer a read attempt without added latency, save a standard-mode read stalled by a full output buffer.
// - Read reaches full after 1 read, (N-1)*4 quick, 3 write ticks.
// - Read reaches programmable full after 1 read, (N-1)*3 quick, 4 write ticks.
// - Standard mode write reaches empty after 1 write, (N-1)*4 quick, 4 read.
// - Write reaches programmable empty after 1 write, (N-1)*4 quick, 4 read.
// - Prefetch mode write reaches empty after 1 write, (N-1)*5 quick, 4 read.
// - Full or empty release comes at the nominal latency, never one cycle past.
// - Write acknowledge and overflow change only on write activity.
// - Valid and underflow change only on read activity.
// - Full is pessimistic and asserts at the write tick that fills the FIFO.
module dcf_fifo_flags (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      prefetch_read_mode_i,
    output logic                           wr_tick_o,
    output logic                           rd_tick_o,
    input  wire logic                      wr_en_i,
    input  wire logic [dcf_pkg::DATA_W-1:0] wr_data_i,
    output logic                           full_o,
    output logic                           prog_full_o,
    output logic                           wr_ack_o,
    output logic                           overflow_o,
    input  wire logic                      rd_en_i,
    output logic                           empty_o,
    output logic                           prog_empty_o,
    output logic                           valid_o,
    output logic                           underflow_o,
    output logic      [dcf_pkg::DATA_W-1:0] rd_data_o,
    output logic                           rd_data_valid_o,
    input  wire logic                      rd_data_ready_i
);
    import dcf_pkg::*;

    // ------------------------------------------------------------------
    // Rate dividers: write side, read side and the quicker of the two
    // ------------------------------------------------------------------
    logic [DIV_W-1:0] wr_div_q, wr_div_d;
    logic [DIV_W-1:0] rd_div_q, rd_div_d;
    logic             wr_tick, rd_tick, fast_tick;
    logic             mode_q, mode_d;

    assign wr_tick   = (wr_div_q == DIV_RST);
    assign rd_tick   = (rd_div_q == DIV_RST);
    // Fixed by configuration so latencies never shift mid-run
    assign fast_tick = FAST_IS_WR ? wr_tick : rd_tick;
    assign wr_tick_o = wr_tick;
    assign rd_tick_o = rd_tick;

    always_comb
    begin
        wr_div_d = wr_tick ? DIV_W'(WR_DIV - 1) : wr_div_q - 8'h0_1;
        rd_div_d = rd_tick ? DIV_W'(RD_DIV - 1) : rd_div_q - 8'h0_1;
        // Read mode is a strap: caught while reset is held, frozen after
        mode_d   = rst_n_i ? mode_q : prefetch_read_mode_i;
    end

    always_ff @(posedge clk_i)
    begin
        mode_q <= mode_d;
        if (!rst_n_i)
        begin
            wr_div_q <= DIV_RST;
            rd_div_q <= DIV_RST;
        end
        else
        begin
            wr_div_q <= wr_div_d;
            rd_div_q <= rd_div_d;
        end
    end

    // ------------------------------------------------------------------
    // Cross-side latency pipes
    // ------------------------------------------------------------------
    logic             wr_do, rd_pop;
    logic [EV_W-1:0]  rd_at_full, rd_at_pfull;
    logic [EV_W-1:0]  wr_at_emps, wr_at_empp, wr_at_pemp, wr_at_empty;

    // Depth factor N_EFF carries the cascade and small-cascade choice
    dcf_lat_pipe #(.SEG_A(FULL_L1), .SEG_B(FULL_SEG_B), .SEG_C(FULL_L3)) u_full_pipe (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .tick_a_i (rd_tick),
        .tick_b_i (fast_tick),
        .tick_c_i (wr_tick),
        .ev_i     (EV_W'(rd_pop)),
        .ev_o     (rd_at_full)
    );

    dcf_lat_pipe #(.SEG_A(PFULL_L4), .SEG_B(PFULL_SEG_B), .SEG_C(PFULL_SEG_C)) u_pfull_pipe (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .tick_a_i (rd_tick),
        .tick_b_i (fast_tick),
        .tick_c_i (wr_tick),
        .ev_i     (EV_W'(rd_pop)),
        .ev_o     (rd_at_pfull)
    );

    dcf_lat_pipe #(.SEG_A(EMPS_L1), .SEG_B(EMPS_SEG_B), .SEG_C(EMPS_L3)) u_emps_pipe (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .tick_a_i (wr_tick),
        .tick_b_i (fast_tick),
        .tick_c_i (rd_tick),
        .ev_i     (EV_W'(wr_do)),
        .ev_o     (wr_at_emps)
    );

    dcf_lat_pipe #(.SEG_A(EMPS_L1), .SEG_B(EMPP_SEG_B), .SEG_C(EMPS_L3)) u_empp_pipe (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .tick_a_i (wr_tick),
        .tick_b_i (fast_tick),
        .tick_c_i (rd_tick),
        .ev_i     (EV_W'(wr_do)),
        .ev_o     (wr_at_empp)
    );

    dcf_lat_pipe #(.SEG_A(PEMP_L4), .SEG_B(PEMP_SEG_B), .SEG_C(PEMP_SEG_C)) u_pemp_pipe (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .tick_a_i (wr_tick),
        .tick_b_i (fast_tick),
        .tick_c_i (rd_tick),
        .ev_i     (EV_W'(wr_do)),
        .ev_o     (wr_at_pemp)
    );

    // Nominal latency only; the extra phase cycle never occurs here
    assign wr_at_empty = mode_q ? wr_at_empp : wr_at_emps;

    // ------------------------------------------------------------------
    // Write side
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] full_cnt_q, full_cnt_d, pf_cnt_q, pf_cnt_d;
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
    logic             full_q, full_d, prog_full_q, prog_full_d;
    logic             wr_ack_q, wr_ack_d, overflow_q, overflow_d;
    logic             wr_try;

    assign wr_try = wr_tick & wr_en_i;
    assign wr_do  = wr_try & ~full_q;

    always_comb
    begin
        // Reads are only credited once the pipe delivers them
        full_cnt_d  = full_cnt_q + CNT_W'(wr_do) - CNT_W'(rd_at_full);
        full_d      = (full_cnt_d == FULL_LEVEL);
        pf_cnt_d    = pf_cnt_q + CNT_W'(wr_do) - CNT_W'(rd_at_pfull);
        prog_full_d = wr_tick ? (pf_cnt_q >= PROG_FULL_THR) : prog_full_q;
        wr_ack_d    = wr_tick ? wr_do : wr_ack_q;
        overflow_d  = wr_tick ? (wr_try & full_q) : overflow_q;
        wr_ptr_d    = wr_do ? wr_ptr_q + 10'h0_01 : wr_ptr_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            full_cnt_q  <= CNT_RST;
            pf_cnt_q    <= CNT_RST;
            full_q      <= FULL_RST;
            prog_full_q <= FULL_RST;
            wr_ack_q    <= 1'b0;
            overflow_q  <= 1'b0;
            wr_ptr_q    <= PTR_RST;
        end
        else
        begin
            full_cnt_q  <= full_cnt_d;
            pf_cnt_q    <= pf_cnt_d;
            full_q      <= full_d;
            prog_full_q <= prog_full_d;
            wr_ack_q    <= wr_ack_d;
            overflow_q  <= overflow_d;
            wr_ptr_q    <= wr_ptr_d;
        end
    end

    assign full_o      = full_q;
    assign prog_full_o = prog_full_q;
    assign wr_ack_o    = wr_ack_q;
    assign overflow_o  = overflow_q;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
    logic [PTR_W-1:0]  rd_ptr_q, rd_ptr_d;

    always_ff @(posedge clk_i)
    begin
        if (wr_do)
            mem_q[wr_ptr_q] <= wr_data_i;
    end

    // ------------------------------------------------------------------
    // Read side
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] emp_cnt_q, emp_cnt_d, pe_cnt_q, pe_cnt_d;
    logic             empty_q, empty_d, prog_empty_q, prog_empty_d;
    logic             valid_q, valid_d, underflow_q, underflow_d;
    logic             rd_try, buf_room, out_valid, out_ready;

    assign rd_try = rd_tick & rd_en_i;
    // Prefetch fetches the head on its own; a full buffer stalls the pop
    assign rd_pop = rd_tick & ~empty_q & buf_room & (mode_q | rd_en_i);

    always_comb
    begin
        emp_cnt_d    = emp_cnt_q + CNT_W'(wr_at_empty) - CNT_W'(rd_pop);
        empty_d      = (emp_cnt_d == CNT_RST);
        pe_cnt_d     = pe_cnt_q + CNT_W'(wr_at_pemp) - CNT_W'(rd_pop);
        prog_empty_d = rd_tick ? (pe_cnt_q <= PROG_EMPTY_THR) : prog_empty_q;
        valid_d      = valid_q;
        underflow_d  = underflow_q;
        if (rd_tick)
        begin
            valid_d     = mode_q ? (rd_try & out_valid) : rd_pop;
            underflow_d = rd_try & (mode_q ? ~out_valid : empty_q);
        end
        rd_ptr_d     = rd_pop ? rd_ptr_q + 10'h0_01 : rd_ptr_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            emp_cnt_q    <= CNT_RST;
            pe_cnt_q     <= CNT_RST;
            empty_q      <= EMPTY_RST;
            prog_empty_q <= EMPTY_RST;
            valid_q      <= 1'b0;
            underflow_q  <= 1'b0;
            rd_ptr_q     <= PTR_RST;
        end
        else
        begin
            emp_cnt_q    <= emp_cnt_d;
            pe_cnt_q     <= pe_cnt_d;
            empty_q      <= empty_d;
            prog_empty_q <= prog_empty_d;
            valid_q      <= valid_d;
            underflow_q  <= underflow_d;
            rd_ptr_q     <= rd_ptr_d;
        end
    end

    assign empty_o      = empty_q;
    assign prog_empty_o = prog_empty_q;
    assign valid_o      = valid_q;
    assign underflow_o  = underflow_q;

    // ------------------------------------------------------------------
    // Two-entry output buffer: a stalled receiver holds words, loses none
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] buf_q [BUF_DEPTH];
    logic [DATA_W-1:0] buf_d [BUF_DEPTH];
    logic              head_q, head_d;
    logic [1:0]        buf_cnt_q, buf_cnt_d;
    logic              buf_pop;
    logic              tail;

    assign out_valid       = (buf_cnt_q != 2'h0);
    assign buf_room        = (buf_cnt_q != 2'h2);
    // In prefetch mode the read enable takes the head word
    assign out_ready       = mode_q ? rd_try : rd_data_ready_i;
    assign buf_pop         = out_valid & out_ready;
    assign tail            = head_q ^ buf_cnt_q[0];
    assign rd_data_o       = buf_q[head_q];
    assign rd_data_valid_o = out_valid;

    always_comb
    begin
        buf_d     = buf_q;
        if (rd_pop)
            buf_d[tail] = mem_q[rd_ptr_q];
        head_d    = buf_pop ? ~head_q : head_q;
        buf_cnt_d = buf_cnt_q + 2'(rd_pop) - 2'(buf_pop);
    end

    always_ff @(posedge clk_i)
    begin
        buf_q <= buf_d;
        if (!rst_n_i)
        begin
            head_q    <= 1'b0;
            buf_cnt_q <= 2'h0;
        end
        else
        begin
            head_q    <= head_d;
            buf_cnt_q <= buf_cnt_d;
        end
    end

endmodule : dcf_fifo_flags

/* File: verification/dcf_fifo_flags_chk.sv */
`timescale 1ns/1ps
module dcf_fifo_flags_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic prefetch_read_mode_i,
    input wire logic wr_tick_o,
    input wire logic rd_tick_o,
    input wire logic wr_en_i,
    input wire logic full_o,
    input wire logic prog_full_o,
    input wire logic wr_ack_o,
    input wire logic overflow_o,
    input wire logic rd_en_i,
    input wire logic empty_o,
    input wire logic prog_empty_o,
    input wire logic valid_o,
    input wire logic underflow_o,
    input wire logic rd_data_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----
    // Handshake answers
    // ----
    a_wr_ack_take: assert property (wr_tick_o && wr_en_i && !full_o |=> wr_ack_o && !overflow_o)
        else $error("write not acknowledged");
    a_ovf_refuse: assert property (wr_tick_o && wr_en_i && full_o |=> overflow_o && !wr_ack_o)
        else $error("overflow missing");
    a_wr_hs_hold: assert property (!wr_tick_o |=> $stable({wr_ack_o, overflow_o}))
        else $error("write handshake moved off a write tick");
    a_rd_hs_hold: assert property (!rd_tick_o |=> $stable({valid_o, underflow_o}))
        else $error("read handshake moved off a read tick");
    a_uflow_std: assert property (!prefetch_read_mode_i && rd_tick_o && rd_en_i && empty_o
        |=> underflow_o && !valid_o) else $error("underflow missing");
    a_valid_std: assert property (!prefetch_read_mode_i && rd_tick_o && rd_en_i && !empty_o
        && !rd_data_valid_o |=> valid_o) else $error("valid missing");
    a_valid_pref: assert property (prefetch_read_mode_i && rd_tick_o && rd_en_i
        |=> valid_o == $past(rd_data_valid_o) && underflow_o != valid_o)
        else $error("prefetch read answer wrong");
    // ----
    // Flag timing
    // ----
    a_full_rise: assert property ($rose(full_o) |-> $past(wr_tick_o && wr_en_i))
        else $error("full rose without a write");
    a_empty_rise: assert property ($rose(empty_o) |-> $past(rd_tick_o))
        else $error("empty rose off a read tick");
    a_wr_flag_dom: assert property (!wr_tick_o |=> $stable({full_o, prog_full_o}))
        else $error("write flags moved off a write tick");
    a_rd_flag_dom: assert property (!rd_tick_o |=> $stable({empty_o, prog_empty_o}))
        else $error("read flags moved off a read tick");
    a_wr_tick_rate: assert property (wr_tick_o |=> !wr_tick_o ##1 wr_tick_o)
        else $error("write tick rate wrong");
    a_rd_tick_rate: assert property (rd_tick_o |=> !rd_tick_o [*2] ##1 rd_tick_o)
        else $error("read tick rate wrong");
    c_overflow: cover property (wr_tick_o && wr_en_i && full_o);
    c_underflow: cover property (rd_tick_o && rd_en_i && empty_o);
    c_full_fall: cover property ($fell(full_o));
    c_pref_read: cover property (prefetch_read_mode_i && valid_o);
endmodule : dcf_fifo_flags_chk

bind dcf_fifo_flags dcf_fifo_flags_chk i_dcf_fifo_flags_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .prefetch_read_mode_i(prefetch_read_mode_i),
    .wr_tick_o(wr_tick_o), .rd_tick_o(rd_tick_o), .wr_en_i(wr_en_i), .full_o(full_o),
    .prog_full_o(prog_full_o), .wr_ack_o(wr_ack_o), .overflow_o(overflow_o),
    .rd_en_i(rd_en_i), .empty_o(empty_o), .prog_empty_o(prog_empty_o), .valid_o(valid_o),
    .underflow_o(underflow_o), .rd_data_valid_o(rd_data_valid_o)
);

/* File: verification/dcf_user_sink.sv */
`timescale 1ns/1ps
module dcf_user_sink
    import dcf_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              slow_i,
    input  wire logic              valid_i,
    output logic                   ready_o,
    output logic                   got_o
);
    logic [2:0] ph_q;
    always_ff @(posedge clk_i)
        ph_q <= rst_n_i ? ph_q + 3'h1 : 3'h0;
    // Slow drain takes one word in eight cycles, so the buffer backs up
    assign ready_o = !slow_i || (ph_q == 3'h7);
    assign got_o   = valid_i && ready_o;
endmodule : dcf_user_sink

/* File: verification/tb_dcf_fifo_flags.sv */
`timescale 1ns/1ps
module tb_dcf_fifo_flags;
    import dcf_pkg::*;
    localparam int WR = 0;
    localparam int RD = 1;
    localparam int FAST = FAST_IS_WR ? WR : RD;
    localparam int NQ = N_EFF - 1;
    logic clk_i = 1'b0, rst_n_i = 1'b0, prefetch_read_mode_i = 1'b0, slow = 1'b0;
    logic wr_en_i = 1'b0, rd_en_i = 1'b0, rd_data_ready_i, got;
    logic [DATA_W-1:0] wr_data_i = 8'h00, rd_data_o, q[$];
    logic wr_tick_o, rd_tick_o, full_o, prog_full_o, wr_ack_o, overflow_o;
    logic empty_o, prog_empty_o, valid_o, underflow_o, rd_data_valid_o;
    logic [31:0] seed = 32'h0000_c6a9;
    int errors = 0, tests_run = 0;
    dcf_fifo_flags i_dcf_fifo_flags (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .prefetch_read_mode_i(prefetch_read_mode_i), .wr_tick_o(wr_tick_o),
        .rd_tick_o(rd_tick_o), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .full_o(full_o),
        .prog_full_o(prog_full_o), .wr_ack_o(wr_ack_o), .overflow_o(overflow_o),
        .rd_en_i(rd_en_i), .empty_o(empty_o), .prog_empty_o(prog_empty_o),
        .valid_o(valid_o), .underflow_o(underflow_o), .rd_data_o(rd_data_o),
        .rd_data_valid_o(rd_data_valid_o), .rd_data_ready_i(rd_data_ready_i));
    dcf_user_sink i_dcf_user_sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .valid_i(rd_data_valid_o), .ready_o(rd_data_ready_i), .got_o(got));
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    // ----
    // Helpers
    // ----
    task automatic final_report();
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic chk_flag(input logic g, input logic e);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_flag
    task automatic chk_word(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_word
    function automatic logic [DATA_W-1:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[DATA_W-1:0];
    endfunction : rnd
    function automatic logic flg(input int s);
        return s == 0 ? full_o : s == 1 ? prog_full_o : s == 2 ? empty_o : prog_empty_o;
    endfunction : flg
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            wr_en_i <= 1'b0;
            rd_en_i <= 1'b0;
        end
        #1;
    endtask : idle
    task automatic rst(input logic pf);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        prefetch_read_mode_i <= pf;
        wr_en_i <= 1'b0;
        rd_en_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        q.delete();
        #1;
        chk_flag(empty_o, 1'b1);
    endtask : rst
    // Enables stay high on return so that the next call lands on the next tick
    task automatic wr1(input logic [DATA_W-1:0] d, input logic ov);
        @(posedge clk_i);
        wr_en_i <= 1'b1;
        wr_data_i <= d;
        #1;
        while (wr_tick_o !== 1'b1) idle(0) ;
        idle(0);
        @(posedge clk_i);
        #1;
        chk_flag(wr_ack_o, !ov);
        chk_flag(overflow_o, ov);
        if (!ov) q.push_back(d);
    endtask : wr1
    task automatic rd1(input logic uf);
        @(posedge clk_i);
        rd_en_i <= 1'b1;
        #1;
        for (int t = 0; t < 40; t++)
        begin
            while (rd_tick_o !== 1'b1)
            begin
                @(posedge clk_i);
                #1;
            end
            @(posedge clk_i);
            #1;
            if ((valid_o | underflow_o) === 1'b1) break;
        end
        chk_flag(valid_o, !uf);
        chk_flag(underflow_o, uf);
    endtask : rd1
    // Counts ticks strictly after the event; the flag must hold until the last one
    task automatic lat(input int s, input logic v, input int d0, n0, d1, n1, d2, n2);
        int d[3];
        int n[3];
        int left;
        d = '{d0, d1, d2};
        n = '{n0, n1, n2};
        left = n0 + n1 + n2;
        for (int i = 0; i < 3; i++)
            while (n[i] > 0)
            begin
                if ((d[i] == RD ? rd_tick_o : wr_tick_o) === 1'b1)
                begin
                    n[i]--;
                    left--;
                    if (left == 0) chk_flag(flg(s), !v);
                end
                idle(1);
            end
        chk_flag(flg(s), v);
    endtask : lat
    always @(posedge clk_i)
        if (rst_n_i && got === 1'b1 && !prefetch_read_mode_i && q.size() > 0)
            chk_word(rd_data_o, q.pop_front());
    // ----
    // Scenarios
    // ----
    initial
    begin
        rst(1'b0);
        rd1(1'b1);
        wr1(rnd(), 1'b0);
        lat(2, 1'b0, WR, 1, FAST, 4 * NQ, RD, 4);
        repeat (8) wr1(rnd(), 1'b0);
        lat(3, 1'b0, WR, 1, FAST, 4 * NQ, RD, 4);
        rd1(1'b0);
        lat(3, 1'b1, RD, 1, RD, 0, RD, 0);
        repeat (8) rd1(1'b0);
        chk_flag(empty_o, 1'b1);
        rd1(1'b1);
        idle(10);
        for (int i = 0; i < 1024; i++)
        begin
            wr1(rnd(), 1'b0);
            if (i == 999) lat(1, 1'b1, WR, 1, WR, 0, WR, 0);
        end
        chk_flag(full_o, 1'b1);
        wr1(8'h00, 1'b1);
        slow = 1'b1;
        rd1(1'b0);
        lat(0, 1'b0, RD, 1, FAST, 4 * NQ, WR, 3);
        repeat (24) rd1(1'b0);
        lat(1, 1'b0, RD, 1, FAST, 3 * NQ, WR, 4);
        repeat (999) rd1(1'b0);
        idle(40);
        chk_word(8'(q.size()), 8'h00);
        rst(1'b1);
        wr1(8'hc3, 1'b0);
        lat(2, 1'b0, WR, 1, FAST, 5 * NQ, RD, 4);
        idle(12);
        chk_word(rd_data_o, 8'hc3);
        rd1(1'b0);
        rd1(1'b1);
        final_report();
    end
    initial
    begin
        repeat (40000) @(posedge clk_i);
        errors++;
        final_report();
    end
endmodule : tb_dcf_fifo_flags
